//--- hw/coil_reg_pkg.sv
// Shared constants for the coil and holding-register command handler
package coil_reg_pkg;
    localparam logic [7:0]  FC_WRITE_COIL      = 8'h05;
    localparam logic [7:0]  FC_WRITE_COILS     = 8'h0F;
    localparam logic [7:0]  FC_READ_REGS       = 8'h03;
    localparam logic [7:0]  FC_WRITE_REG       = 8'h06;
    localparam logic [7:0]  FC_WRITE_REGS      = 8'h10;
    localparam logic [7:0]  BROADCAST_ADDR     = 8'h00;
    localparam logic [15:0] FORCE_ON           = 16'hFF00;
    localparam logic [15:0] FORCE_OFF          = 16'h0000;
    localparam logic [15:0] PARAM_WRITE_COIL   = 16'h0040;
    localparam logic [15:0] SPEED_COIL_BASE    = 16'h0010;
    localparam logic [15:0] SPEED_COIL_QTY     = 16'h0010;
    localparam logic [15:0] CTRL_COIL_BASE     = 16'h0000;
    localparam logic [15:0] PARAM_SCALE        = 16'h000A;
    localparam logic [15:0] CTRL_WORD_RESET    = 16'h0000;
    localparam int          REG_DEPTH_LOG2     = 4;
    localparam int          MAX_FRAME          = 40;
    // Controller registers on APB
    localparam logic [7:0]  OFS_CMD            = 8'h00;
    localparam logic [7:0]  OFS_ADDR           = 8'h04;
    localparam logic [7:0]  OFS_QTY            = 8'h08;
    localparam logic [7:0]  OFS_DATA           = 8'h0C;
    localparam logic [7:0]  OFS_STATUS         = 8'h10;
    localparam logic [7:0]  OFS_RDATA          = 8'h14;
    localparam logic [7:0]  OFS_SLAVE          = 8'h18;
endpackage

//--- hw/modbus_link_if.sv
// Byte-stream link between the query master and the drive command handler
`timescale 1ns/1ps
interface modbus_link_if;
    logic       q_valid;
    logic [7:0] q_byte;
    logic       q_last;
    logic       r_valid;
    logic [7:0] r_byte;
    logic       r_last;
    modport slave  (input q_valid, input q_byte, input q_last, output r_valid, output r_byte, output r_last);
    modport master (output q_valid, output q_byte, output q_last, input r_valid, input r_byte, input r_last);
endinterface

//--- hw/modbus_coil_register_handler.sv
// Drive-side Modbus command handler: coils, holding registers, control word
`timescale 1ns/1ps
module modbus_coil_register_handler
    import coil_reg_pkg::*;
#(
    parameter logic [7:0] SLAVE_ID = 8'h01
) (
    input  wire logic   pclk,
    input  wire logic   presetn,
    modbus_link_if.slave link,
    output logic [15:0] speed_setpoint,
    output logic [15:0] drive_control_word,
    output logic [1:0]  preset_ref_sel,
    output logic        dc_brake_n,
    output logic        coast_n,
    output logic        quick_stop_n,
    output logic        hold_freq_n,
    output logic        ramp_start,
    output logic        trip_reset,
    output logic        jog,
    output logic        ramp2_sel,
    output logic        data_valid,
    output logic        relay1,
    output logic        relay2,
    output logic [1:0]  setup_sel,
    output logic        reverse,
    output logic        param_wr,
    output logic [15:0] param_num,
    output logic [31:0] param_wdata,
    output logic        param_nvm,
    output logic        param_32
);
    typedef enum logic [1:0] {RX, EXEC, TX} hstate_e;
    hstate_e     state_ff;
    logic [7:0]  buf_ff [MAX_FRAME];
    logic [5:0]  len_ff;
    logic [5:0]  txi_ff;
    logic [5:0]  txn_ff;
    logic        pwc_ff;
    logic [15:0] regs_ff [1 << REG_DEPTH_LOG2];
    logic [15:0] ctrl_ff;
    logic [7:0]  rv_ff;
    logic        rvv_ff;
    logic        rl_ff;
    logic [15:0] f_addr;
    logic [15:0] f_val;
    logic [15:0] f_qty;
    logic [4:0]  ri;
    logic [15:0] coil_bits;
    integer      k;
    logic [15:0] rd_word;
    logic        is_read;

    // Broadcast queries are executed but never answered
    function automatic logic is_bcast(input logic [7:0] dest);
        return dest == BROADCAST_ADDR;
    endfunction

    // Holding-register RAM index from a zero-based link address
    function automatic logic [REG_DEPTH_LOG2-1:0] reg_index(input logic [15:0] addr);
        return addr[REG_DEPTH_LOG2-1:0];
    endfunction

    assign is_read   = (buf_ff[1] == FC_READ_REGS);
    assign f_addr    = {buf_ff[2], buf_ff[3]};
    assign f_val     = {buf_ff[4], buf_ff[5]};
    assign f_qty     = {buf_ff[4], buf_ff[5]};
    assign coil_bits = {buf_ff[8], buf_ff[7]};
    assign link.r_valid = rvv_ff;
    assign link.r_byte  = rv_ff;
    assign link.r_last  = rl_ff;

    // Query intake and execution
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_ff    <= RX;
            len_ff      <= 6'h00;
            txn_ff      <= 6'h00;
            pwc_ff      <= 1'b0;
            ctrl_ff     <= CTRL_WORD_RESET;
            speed_setpoint <= 16'h0000;
            param_wr    <= 1'b0;
            param_num   <= 16'h0000;
            param_wdata <= 32'h0000_0000;
            param_nvm   <= 1'b0;
            param_32    <= 1'b0;
            for (k = 0; k < MAX_FRAME; k++) buf_ff[k] <= 8'h00;
            for (k = 0; k < (1 << REG_DEPTH_LOG2); k++) regs_ff[k] <= 16'h0000;
        end else begin
            param_wr <= 1'b0;
            case (state_ff)
                RX: begin
                    if (link.q_valid) begin
                        if (len_ff < 6'(MAX_FRAME)) buf_ff[len_ff] <= link.q_byte;
                        len_ff <= len_ff + 6'h01;
                        if (link.q_last) state_ff <= EXEC;
                    end
                end
                EXEC: begin
                    len_ff   <= 6'h00;
                    state_ff <= RX;
                    if (buf_ff[0] == SLAVE_ID || is_bcast(buf_ff[0])) begin
                        state_ff <= is_bcast(buf_ff[0]) ? RX : TX;
                        txn_ff   <= 6'd6;
                        case (buf_ff[1])
                            FC_WRITE_COIL: begin
                                if (f_addr == PARAM_WRITE_COIL) begin
                                    if (f_val == FORCE_ON) pwc_ff <= 1'b1;
                                    else if (f_val == FORCE_OFF) pwc_ff <= 1'b0;
                                end
                            end
                            FC_WRITE_COILS: begin
                                if (f_addr == SPEED_COIL_BASE && f_qty == SPEED_COIL_QTY)
                                    speed_setpoint <= coil_bits;
                                else if (f_addr == CTRL_COIL_BASE && f_qty == SPEED_COIL_QTY)
                                    ctrl_ff <= coil_bits;
                            end
                            FC_READ_REGS: begin
                                txn_ff <= 6'(3 + 2 * f_qty[3:0]);
                            end
                            FC_WRITE_REG: begin
                                regs_ff[reg_index(f_addr)] <= f_val;
                                param_wr    <= 1'b1;
                                param_num   <= (f_addr + 16'h0001) / PARAM_SCALE;
                                param_wdata <= {16'h0000, f_val};
                                param_32    <= 1'b0;
                                param_nvm   <= pwc_ff;
                            end
                            FC_WRITE_REGS: begin
                                regs_ff[reg_index(f_addr)] <= {buf_ff[7], buf_ff[8]};
                                regs_ff[reg_index(f_addr + 16'h0001)] <= {buf_ff[9], buf_ff[10]};
                                param_wr    <= 1'b1;
                                param_num   <= (f_addr + 16'h0001) / PARAM_SCALE;
                                param_wdata <= {buf_ff[7], buf_ff[8], buf_ff[9], buf_ff[10]};
                                param_32    <= (f_qty == 16'h0002);
                                param_nvm   <= pwc_ff;
                            end
                            default: state_ff <= RX;
                        endcase
                    end
                end
                TX: if (txi_ff == txn_ff) state_ff <= RX;
                default: state_ff <= RX;
            endcase
        end
    end

    // Reply byte stream
    assign ri = 5'((txi_ff - 6'd3) >> 1);
    assign rd_word = regs_ff[reg_index(f_addr + 16'(ri))];
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            txi_ff <= 6'h00;
            rvv_ff <= 1'b0;
            rv_ff  <= 8'h00;
            rl_ff  <= 1'b0;
        end else if (state_ff == TX && txi_ff < txn_ff) begin
            rvv_ff <= 1'b1;
            rl_ff  <= (txi_ff == txn_ff - 6'h01);
            txi_ff <= txi_ff + 6'h01;
            if (is_read && txi_ff == 6'd2)
                rv_ff <= 8'(2 * f_qty[3:0]);
            else if (is_read && txi_ff > 6'd2)
                rv_ff <= txi_ff[0] ? rd_word[15:8] : rd_word[7:0];
            else
                rv_ff <= buf_ff[txi_ff];
        end else begin
            rvv_ff <= 1'b0;
            rl_ff  <= 1'b0;
            txi_ff <= 6'h00;
        end
    end

    // Control word decode
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            drive_control_word <= CTRL_WORD_RESET;
            {reverse, setup_sel, relay2, relay1, data_valid, ramp2_sel, jog} <= 8'h00;
            {trip_reset, ramp_start, hold_freq_n, quick_stop_n, coast_n, dc_brake_n, preset_ref_sel} <= 8'h00;
        end else begin
            drive_control_word <= ctrl_ff;
            {preset_ref_sel, dc_brake_n, coast_n, quick_stop_n, hold_freq_n, ramp_start}
                <= {ctrl_ff[1:0], ctrl_ff[2], ctrl_ff[3], ctrl_ff[4], ctrl_ff[5], ctrl_ff[6]};
            trip_reset <= ctrl_ff[7] & ~drive_control_word[7];
            {jog, ramp2_sel, data_valid, relay1, relay2, setup_sel, reverse}
                <= {ctrl_ff[8], ctrl_ff[9], ctrl_ff[10], ctrl_ff[11], ctrl_ff[12], ctrl_ff[14:13], ctrl_ff[15]};
        end
    end
endmodule // modbus_coil_register_handler

//--- hw/modbus_query_master.sv
// APB-commanded query master that sends Modbus queries over the byte link
`timescale 1ns/1ps
module modbus_query_master
    import coil_reg_pkg::*;
(
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output logic [31:0]      prdata,
    output logic             pready,
    output logic             pslverr,
    modbus_link_if.master    link
);
    logic [7:0]  cmd_ff;
    logic [7:0]  slv_ff;
    logic [15:0] addr_ff;
    logic [15:0] qty_ff;
    logic [31:0] data_ff;
    logic        busy_ff;
    logic [3:0]  qi_ff;
    logic [3:0]  qn;
    logic [7:0]  qb;
    logic [31:0] rd_ff;
    logic [5:0]  rcnt_ff;
    logic        qv_ff;
    logic [7:0]  qbyte_ff;
    logic        ql_ff;
    logic        wr;

    assign link.q_valid = qv_ff;
    assign link.q_byte  = qbyte_ff;
    assign link.q_last  = ql_ff;
    assign wr = psel & penable & pwrite;

    // Query layout per function code
    always_comb begin
        qn = 4'd6;
        qb = 8'h00;
        if (cmd_ff == FC_WRITE_COILS) qn = 4'd9;
        if (cmd_ff == FC_WRITE_REGS)  qn = 4'd11;
        case (qi_ff)
            4'd0: qb = slv_ff;
            4'd1: qb = cmd_ff;
            4'd2: qb = addr_ff[15:8];
            4'd3: qb = addr_ff[7:0];
            4'd4: qb = (cmd_ff == FC_WRITE_COIL || cmd_ff == FC_WRITE_REG) ? data_ff[15:8] : qty_ff[15:8];
            4'd5: qb = (cmd_ff == FC_WRITE_COIL || cmd_ff == FC_WRITE_REG) ? data_ff[7:0] : qty_ff[7:0];
            4'd6: qb = (cmd_ff == FC_WRITE_REGS) ? 8'h04 : 8'h02;
            4'd7: qb = (cmd_ff == FC_WRITE_REGS) ? data_ff[31:24] : data_ff[7:0];
            4'd8: qb = (cmd_ff == FC_WRITE_REGS) ? data_ff[23:16] : data_ff[15:8];
            4'd9: qb = data_ff[15:8];
            4'd10: qb = data_ff[7:0];
            default: qb = 8'h00;
        endcase
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cmd_ff  <= 8'h00;
            slv_ff  <= 8'h01;
            addr_ff <= 16'h0000;
            qty_ff  <= 16'h0000;
            data_ff <= 32'h0000_0000;
        end else if (wr && !busy_ff) begin
            case (paddr)
                OFS_CMD:   cmd_ff  <= pwdata[7:0];
                OFS_ADDR:  addr_ff <= pwdata[15:0];
                OFS_QTY:   qty_ff  <= pwdata[15:0];
                OFS_DATA:  data_ff <= pwdata;
                OFS_SLAVE: slv_ff  <= pwdata[7:0];
                default: ;
            endcase
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            busy_ff  <= 1'b0;
            qi_ff    <= 4'h0;
            qv_ff    <= 1'b0;
            qbyte_ff <= 8'h00;
            ql_ff    <= 1'b0;
            rd_ff    <= 32'h0000_0000;
            rcnt_ff  <= 6'h00;
        end else begin
            qv_ff <= 1'b0;
            ql_ff <= 1'b0;
            if (wr && !busy_ff && paddr == OFS_CMD) begin
                busy_ff <= 1'b1;
                qi_ff   <= 4'h0;
                rcnt_ff <= 6'h00;
            end else if (busy_ff && qi_ff < qn) begin
                qv_ff    <= 1'b1;
                qbyte_ff <= qb;
                ql_ff    <= (qi_ff == qn - 4'h1);
                qi_ff    <= qi_ff + 4'h1;
                if (qi_ff == qn - 4'h1 && slv_ff == BROADCAST_ADDR) busy_ff <= 1'b0;
            end else if (busy_ff && link.r_valid) begin
                rcnt_ff <= rcnt_ff + 6'h01;
                if (rcnt_ff > 6'd2) rd_ff <= {rd_ff[23:0], link.r_byte};
                if (link.r_last) busy_ff <= 1'b0;
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata  <= 32'h0000_0000;
            pready  <= 1'b0;
            pslverr <= 1'b0;
        end else begin
            pready  <= psel & ~penable;
            pslverr <= 1'b0;
            case (paddr)
                OFS_CMD:    prdata <= {24'h0, cmd_ff};
                OFS_ADDR:   prdata <= {16'h0, addr_ff};
                OFS_QTY:    prdata <= {16'h0, qty_ff};
                OFS_DATA:   prdata <= data_ff;
                OFS_STATUS: prdata <= {31'h0, busy_ff};
                OFS_RDATA:  prdata <= rd_ff;
                OFS_SLAVE:  prdata <= {24'h0, slv_ff};
                default: begin
                    prdata  <= 32'h0000_0000;
                    pslverr <= psel & ~penable;
                end
            endcase
        end
    end
endmodule // modbus_query_master

//--- verification/modbus_link_monitor.sv
// Checker for query and reply framing on the byte link
`timescale 1ns/1ps
module modbus_link_monitor
    import coil_reg_pkg::*;
(
    input wire logic       pclk,
    input wire logic       presetn,
    input wire logic       q_valid,
    input wire logic [7:0] q_byte,
    input wire logic       q_last,
    input wire logic       r_valid,
    input wire logic [7:0] r_byte,
    input wire logic       r_last
);
    logic [7:0] q_idx_ff;
    logic [7:0] r_idx_ff;
    logic [7:0] qb_ff [0:5];
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    // Query byte position and first six query bytes
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) q_idx_ff <= 8'h00;
        else if (q_valid) q_idx_ff <= q_last ? 8'h00 : q_idx_ff + 8'h01;
    end
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) qb_ff <= '{default: 8'h00};
        else if (q_valid && q_idx_ff < 8'h06) qb_ff[q_idx_ff[2:0]] <= q_byte;
    end
    // Reply byte position
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) r_idx_ff <= 8'h00;
        else if (r_valid) r_idx_ff <= r_last ? 8'h00 : r_idx_ff + 8'h01;
    end
    sequence s_addressed;
        q_last && qb_ff[0] == 8'h01;
    endsequence
    sequence s_reply_open;
        r_valid && r_idx_ff == 8'h00;
    endsequence
    property p_reply_start;
        s_addressed |-> ##[1:4] s_reply_open;
    endproperty
    a_reply_start: assert property (p_reply_start) else $error("reply did not start after query");
    property p_bcast_silent;
        q_last && qb_ff[0] == BROADCAST_ADDR |=> !r_valid [*8];
    endproperty
    a_bcast_silent: assert property (p_bcast_silent) else $error("reply sent to broadcast");
    property p_echo;
        r_valid && (r_idx_ff < 8'h02 || (r_idx_ff < 8'h06 && qb_ff[1] != FC_READ_REGS))
            |-> r_byte == qb_ff[r_idx_ff[2:0]];
    endproperty
    a_echo: assert property (p_echo) else $error("reply header differs from query");
    property p_count;
        r_valid && r_idx_ff == 8'h02 && qb_ff[1] == FC_READ_REGS |-> r_byte == {qb_ff[5][6:0], 1'b0};
    endproperty
    a_count: assert property (p_count) else $error("wrong read byte count");
    property p_length;
        r_valid && r_last |-> r_idx_ff == ((qb_ff[1] == FC_READ_REGS) ? 8'h02 + {qb_ff[5][6:0], 1'b0} : 8'h05);
    endproperty
    a_length: assert property (p_length) else $error("wrong reply length");
    property p_burst;
        r_valid && !r_last |=> r_valid;
    endproperty
    a_burst: assert property (p_burst) else $error("gap inside reply");
    property p_q_frame;
        q_last |-> q_valid;
    endproperty
    a_q_frame: assert property (p_q_frame) else $error("query end without byte");
    property p_r_frame;
        r_last |-> r_valid;
    endproperty
    a_r_frame: assert property (p_r_frame) else $error("reply end without byte");
    property p_order;
        r_valid |-> !q_valid;
    endproperty
    a_order: assert property (p_order) else $error("query sent during reply");
endmodule // modbus_link_monitor

//--- verification/modbus_coil_register_handler_bench.sv
// Testbench joining query master and command handler over the byte link
`timescale 1ns/1ps
module modbus_coil_register_handler_bench
    import coil_reg_pkg::*;
;
    logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, e;
    logic [7:0]  paddr;
    logic [31:0] pwdata, prdata, q, param_wdata, pw_data;
    logic [15:0] speed_setpoint, drive_control_word, param_num, pw_num;
    logic [1:0]  preset_ref_sel, setup_sel;
    logic        dc_brake_n, coast_n, quick_stop_n, hold_freq_n, ramp_start, trip_reset, jog, ramp2_sel;
    logic        data_valid, relay1, relay2, reverse, param_wr, param_nvm, param_32, pw_nvm, pw_32;
    int          n_mismatch, checks, r_seen, trips, rs0;
    logic [15:0] cws [0:2] = '{16'hE9A5, 16'h16DA, 16'h0000};
    modbus_link_if lk ();
    modbus_query_master u_modbus_query_master (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata,
        .prdata, .pready, .pslverr, .link(lk));
    modbus_coil_register_handler u_modbus_coil_register_handler (.pclk, .presetn, .link(lk), .speed_setpoint,
        .drive_control_word, .preset_ref_sel, .dc_brake_n, .coast_n, .quick_stop_n, .hold_freq_n, .ramp_start,
        .trip_reset, .jog, .ramp2_sel, .data_valid, .relay1, .relay2, .setup_sel, .reverse, .param_wr,
        .param_num, .param_wdata, .param_nvm, .param_32);
    modbus_link_monitor u_modbus_link_monitor (.pclk, .presetn, .q_valid(lk.q_valid), .q_byte(lk.q_byte),
        .q_last(lk.q_last), .r_valid(lk.r_valid), .r_byte(lk.r_byte), .r_last(lk.r_last));
    always #5 pclk = ~pclk;
    // Latch parameter writes, count reply bytes and reset pulses
    always @(posedge pclk) begin
        if (param_wr === 1'b1) {pw_nvm, pw_32, pw_num, pw_data} <= {param_nvm, param_32, param_num, param_wdata};
        if (lk.r_valid === 1'b1) r_seen <= r_seen + 1;
        if (trip_reset === 1'b1) trips <= trips + 1;
    end
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge pclk);
        {psel, penable, pwrite, paddr, pwdata} <= {2'b10, w, a, d};
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        q = prdata;
        e = pslverr;
        {psel, penable} <= 2'b00;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks++;
        if (got !== exp) begin
            n_mismatch++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic run(input logic [7:0] fc, input logic [15:0] a, input logic [15:0] n, input logic [31:0] d);
        int i;
        apb(1'b1, OFS_ADDR, {16'h0000, a});
        apb(1'b1, OFS_QTY, {16'h0000, n});
        apb(1'b1, OFS_DATA, d);
        apb(1'b1, OFS_CMD, {24'h000000, fc});
        i = 0;
        do begin
            apb(1'b0, OFS_STATUS, 32'h00000000);
            i++;
        end while (q[0] !== 1'b0 && i < 300);
        chk({31'h0, q[0]}, 32'h00000000);
        apb(1'b0, OFS_RDATA, 32'h00000000);
    endtask
    task automatic end_sim;
        if (n_mismatch == 0 && checks > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask
    initial begin
        #100000;
        n_mismatch++;
        end_sim;
    end
    initial begin
        {pclk, presetn, psel, penable, pwrite, paddr, pwdata} = '0;
        {n_mismatch, checks, r_seen, trips} = '0;
        repeat (8) @(posedge pclk);
        presetn <= 1'b1;
        chk({16'h0000, drive_control_word}, 32'h00000000);
        apb(1'b0, OFS_SLAVE, 32'h00000000);
        chk(q, 32'h00000001);
        apb(1'b0, 8'h1C, 32'h00000000);
        chk({e, q[30:0]}, 32'h80000000);
        run(FC_WRITE_COIL, PARAM_WRITE_COIL, 16'h0001, {16'h0000, FORCE_ON});
        chk(q, 32'h0040FF00);
        run(FC_WRITE_COILS, SPEED_COIL_BASE, SPEED_COIL_QTY, 32'h00002000);
        chk(q, 32'h00100010);
        chk({16'h0000, speed_setpoint}, 32'h00002000);
        for (int k = 0; k < 3; k++) begin
            run(FC_WRITE_COILS, CTRL_COIL_BASE, 16'h0010, {16'h0000, cws[k]});
            chk({16'h0000, drive_control_word}, {16'h0000, cws[k]});
            chk({16'h0000, reverse, setup_sel, relay2, relay1, data_valid, ramp2_sel, jog, 1'b0, ramp_start,
                hold_freq_n, quick_stop_n, coast_n, dc_brake_n, preset_ref_sel},
                {16'h0000, cws[k] & 16'hFF7F});
            chk(trips, 32'h00000001);
        end
        // Reply bytes from the address low byte onward shift into RDATA
        run(FC_WRITE_REG, 16'h03E7, 16'h0001, 32'h00000001);
        chk(q, 32'h10E70001);
        chk({14'h0, pw_nvm, pw_32, pw_num}, {14'h0, 2'b10, 16'h0064});
        chk(pw_data, 32'h00000001);
        chk({31'h0, param_nvm}, 32'h00000001);
        run(FC_WRITE_REGS, 16'h0419, 16'h0002, 32'h000002E2);
        chk(q, 32'h01190002);
        chk({14'h0, pw_nvm, pw_32, pw_num}, {14'h0, 2'b11, 16'h0069});
        chk(pw_data, 32'h000002E2);
        run(FC_READ_REGS, 16'h0419, 16'h0002, 32'h00000000);
        chk(q, 32'h000002E2);
        apb(1'b1, OFS_SLAVE, {24'h000000, BROADCAST_ADDR});
        rs0 = r_seen;
        run(FC_WRITE_COIL, PARAM_WRITE_COIL, 16'h0001, {16'h0000, FORCE_OFF});
        chk(r_seen, rs0);
        apb(1'b1, OFS_SLAVE, 32'h00000001);
        run(FC_WRITE_REG, 16'h0009, 16'h0001, 32'h00001234);
        chk({14'h0, pw_nvm, pw_32, pw_num}, {14'h0, 2'b00, 16'h0001});
        chk({31'h0, param_nvm}, 32'h00000000);
        run(FC_READ_REGS, 16'h0009, 16'h0001, 32'h00000000);
        chk(q, 32'h12341234);
        end_sim;
    end
endmodule // modbus_coil_register_handler_bench
